// ===== logic/eeprom_seq_pkg.sv
// constants, encodings and the word memory of the eeprom command sequencer
// assumes one bus clock, asynchronous active-high reset and a cpu that never
// writes the array and a register in the same cycle
package eeprom_seq_pkg;

  localparam int unsigned BYTE_ADDR_W  = 11;
  localparam int unsigned WORD_ADDR_W  = 10;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned DIV_W        = 7;

  localparam logic [7:0]  CMD_ERASE_VERIFY  = 8'h05;
  localparam logic [7:0]  CMD_PROGRAM       = 8'h20;
  localparam logic [7:0]  CMD_SECTOR_ERASE  = 8'h40;
  localparam logic [7:0]  CMD_MASS_ERASE    = 8'h41;
  localparam logic [7:0]  CMD_SECTOR_MODIFY = 8'h60;

  // register selects seen on the cpu register write port
  localparam logic [1:0]  REG_SEL_CLKDIV = 2'h0;
  localparam logic [1:0]  REG_SEL_CMD    = 2'h1;
  localparam logic [1:0]  REG_SEL_STATUS = 2'h2;
  localparam logic [1:0]  REG_SEL_OTHER  = 2'h3;

  // status_register bit positions
  localparam int unsigned STAT_COMMAND_BUFFER_EMPTY_FLAG_BIT  = 7;
  localparam int unsigned STAT_CCIF_BIT   = 6;
  localparam int unsigned STAT_ACCESS_ERROR_FLAG_BIT = 4;
  localparam int unsigned STAT_BLANK_BIT  = 2;

  localparam logic [DATA_W-1:0]      ERASED_WORD     = 16'hFFFF;
  localparam logic [DIV_W-1:0]       CLKDIV_RESET    = 7'h00;
  localparam logic [WORD_ADDR_W-1:0] LAST_WORD_ADDR  = 10'h3FF;
  localparam logic [7:0]             CMD_RESET       = 8'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WORD = 2'b01,
    SEQ_CMD  = 2'b11
  } seq_t;

  typedef enum logic [2:0] {
    EX_IDLE   = 3'b000,
    EX_ERASE  = 3'b001,
    EX_PROG   = 3'b011,
    EX_VERIFY = 3'b010,
    EX_VCHK   = 3'b110
  } exec_t;

endpackage

`timescale 1ns/100ps
`default_nettype none

// single-port word array; read data are registered, write has priority
module eeprom_word_mem #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned DATA_W = 16
) (
  // clock
  input  wire logic              clock_i,
  // port
  input  wire logic              we_i,
  input  wire logic              re_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output var  logic [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end else if (re_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule

`default_nettype wire

// ===== logic/eeprom_command_sequencer.sv
// command sequencer of a 2 kbyte eeprom: latches word, command, launch, runs it
// assumes array and register writes arrive as one-cycle strobes, never together
`timescale 1ns/100ps
`default_nettype none

module eeprom_command_sequencer (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // cpu array access
  input  wire logic        array_wr_i,
  input  wire logic        array_byte_i,
  input  wire logic        array_rd_i,
  input  wire logic [10:0] array_addr_i,
  input  wire logic [15:0] array_wdata_i,
  // cpu register writes
  input  wire logic        reg_wr_i,
  input  wire logic [1:0]  reg_sel_i,
  input  wire logic [7:0]  reg_wdata_i,
  // mode and protection
  input  wire logic        normal_mode_i,
  input  wire logic        protection_disable_bit_i,
  input  wire logic        protection_open_bit_i,
  // read answer
  output logic [15:0]      array_rdata_o,
  output logic             array_rdata_valid_o,
  output logic             read_refused_o,
  // status
  output logic [7:0]       status_register_o,
  output logic [6:0]       clock_divider_register_o,
  output logic             busy_o
);

  typedef struct packed {
    eeprom_seq_pkg::seq_t  seq;
    eeprom_seq_pkg::exec_t exec;
    logic                  command_buffer_empty_flag;
    logic                  ccif;
    logic                  access_error_flag;
    logic                  blank;
    logic                  div_set;
    logic [6:0]            div_val;
    logic [6:0]            div_cnt;
    logic                  buf_full;
    logic [7:0]            buf_cmd;
    logic [9:0]            buf_addr;
    logic [15:0]           buf_data;
    logic [9:0]            ex_addr;
    logic [9:0]            ex_end;
    logic [9:0]            ex_word;
    logic [15:0]           ex_data;
    logic                  ex_prog_after;
    logic                  blank_ok;
    logic                  rd_pend;
    logic                  rdata_valid;
    logic                  read_refused;
    logic                  busy;
  } state_t;

  state_t      q;
  state_t      d;
  logic        err;
  logic        launch;
  logic        tick;
  logic        mem_we;
  logic        mem_re;
  logic [9:0]  mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  function automatic logic is_valid_cmd(input logic [7:0] code);
    is_valid_cmd = (code == eeprom_seq_pkg::CMD_ERASE_VERIFY) ||
                   (code == eeprom_seq_pkg::CMD_PROGRAM) ||
                   (code == eeprom_seq_pkg::CMD_SECTOR_ERASE) ||
                   (code == eeprom_seq_pkg::CMD_MASS_ERASE) ||
                   (code == eeprom_seq_pkg::CMD_SECTOR_MODIFY);
  endfunction

  eeprom_word_mem #(
    .ADDR_W (eeprom_seq_pkg::WORD_ADDR_W),
    .DATA_W (eeprom_seq_pkg::DATA_W)
  ) u_mem (
    .clock_i (clock_i),
    .we_i    (mem_we),
    .re_i    (mem_re),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  always_comb begin
    d         = q;
    err       = 1'b0;
    launch    = 1'b0;
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_addr  = q.ex_addr;
    mem_wdata = eeprom_seq_pkg::ERASED_WORD;
    tick      = (q.div_cnt == '0);
    d.rdata_valid  = 1'b0;
    d.read_refused = 1'b0;

    // clearing the error flag comes first so that a new error in the same write wins
    if (reg_wr_i && (reg_sel_i == eeprom_seq_pkg::REG_SEL_STATUS) &&
        reg_wdata_i[eeprom_seq_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) begin
      d.access_error_flag = 1'b0;
    end

    if (array_wr_i) begin
      if (!q.div_set) begin
        err = 1'b1;
      end
      if (array_byte_i || array_addr_i[0]) begin
        err = 1'b1;
      end
      if (!q.command_buffer_empty_flag) begin
        err = 1'b1;
      end
      if (q.seq != eeprom_seq_pkg::SEQ_IDLE) begin
        err = 1'b1;
      end
      if (!err) begin
        d.buf_addr = array_addr_i[10:1];
        d.buf_data = array_wdata_i;
        d.seq      = eeprom_seq_pkg::SEQ_WORD;
      end
    end

    if (reg_wr_i) begin
      unique case (reg_sel_i)
        eeprom_seq_pkg::REG_SEL_CLKDIV: begin
          if (q.seq == eeprom_seq_pkg::SEQ_WORD) begin
            err = 1'b1;
          end else if (q.seq == eeprom_seq_pkg::SEQ_CMD) begin
            err = 1'b1;
          end else begin
            d.div_val = reg_wdata_i[6:0];
            d.div_set = 1'b1;
          end
        end
        eeprom_seq_pkg::REG_SEL_CMD: begin
          if (q.seq == eeprom_seq_pkg::SEQ_CMD) begin
            err = 1'b1;
          end else if (q.seq == eeprom_seq_pkg::SEQ_WORD) begin
            if (is_valid_cmd(reg_wdata_i)) begin
              d.buf_cmd = reg_wdata_i;
              d.seq     = eeprom_seq_pkg::SEQ_CMD;
            end else if (normal_mode_i) begin
              err = 1'b1;
            end
          end
          // a command without a latched word is simply dropped
        end
        eeprom_seq_pkg::REG_SEL_STATUS: begin
          if (q.seq == eeprom_seq_pkg::SEQ_WORD) begin
            err = 1'b1;
          end else if (q.seq == eeprom_seq_pkg::SEQ_CMD) begin
            if (reg_wdata_i[eeprom_seq_pkg::STAT_COMMAND_BUFFER_EMPTY_FLAG_BIT]) begin
              launch = 1'b1;
            end else begin
              err = 1'b1;
            end
          end
        end
        eeprom_seq_pkg::REG_SEL_OTHER: begin
          if (q.seq == eeprom_seq_pkg::SEQ_WORD) begin
            err = 1'b1;
          end else if (q.seq == eeprom_seq_pkg::SEQ_CMD) begin
            err = 1'b1;
          end
        end
      endcase
    end

    if (err) begin
      d.access_error_flag = 1'b1;
      d.seq    = eeprom_seq_pkg::SEQ_IDLE;
    end else if (launch) begin
      d.buf_full = 1'b1;
      d.command_buffer_empty_flag    = 1'b0;
      d.blank    = 1'b0;
      d.seq      = eeprom_seq_pkg::SEQ_IDLE;
    end

    // high-voltage steps are paced by the divider; verify runs at full rate
    if ((q.exec == eeprom_seq_pkg::EX_ERASE) || (q.exec == eeprom_seq_pkg::EX_PROG)) begin
      d.div_cnt = tick ? q.div_val : 7'(q.div_cnt - 7'd1);
    end

    unique case (q.exec)
      eeprom_seq_pkg::EX_IDLE: begin
        if (q.buf_full) begin
          // moving the buffer into the executer frees it for a pipelined command
          d.buf_full      = 1'b0;
          d.command_buffer_empty_flag         = 1'b1;
          d.div_cnt       = q.div_val;
          d.ex_word       = q.buf_addr;
          d.ex_data       = q.buf_data;
          d.ex_prog_after = 1'b0;
          d.ex_addr       = {q.buf_addr[9:1], 1'b0};
          d.ex_end        = {q.buf_addr[9:1], 1'b1};
          unique case (q.buf_cmd)
            eeprom_seq_pkg::CMD_ERASE_VERIFY: begin
              d.ex_addr  = '0;
              d.ex_end   = eeprom_seq_pkg::LAST_WORD_ADDR;
              d.blank_ok = 1'b1;
              d.rd_pend  = 1'b0;
              d.exec     = eeprom_seq_pkg::EX_VERIFY;
            end
            eeprom_seq_pkg::CMD_PROGRAM: begin
              d.exec = eeprom_seq_pkg::EX_PROG;
            end
            eeprom_seq_pkg::CMD_SECTOR_ERASE: begin
              d.exec = eeprom_seq_pkg::EX_ERASE;
            end
            eeprom_seq_pkg::CMD_MASS_ERASE: begin
              // without both protection bits the command completes with no effect
              if (protection_disable_bit_i && protection_open_bit_i) begin
                d.ex_addr = '0;
                d.ex_end  = eeprom_seq_pkg::LAST_WORD_ADDR;
                d.exec    = eeprom_seq_pkg::EX_ERASE;
              end
            end
            default: begin
              d.ex_prog_after = 1'b1;
              d.exec          = eeprom_seq_pkg::EX_ERASE;
            end
          endcase
        end
      end
      eeprom_seq_pkg::EX_ERASE: begin
        if (tick) begin
          mem_we = 1'b1;
          if (q.ex_addr == q.ex_end) begin
            d.exec = q.ex_prog_after ? eeprom_seq_pkg::EX_PROG : eeprom_seq_pkg::EX_IDLE;
          end else begin
            d.ex_addr = 10'(q.ex_addr + 10'd1);
          end
        end
      end
      eeprom_seq_pkg::EX_PROG: begin
        if (tick) begin
          // plain overwrite: the word is expected to be erased already
          mem_we    = 1'b1;
          mem_addr  = q.ex_word;
          mem_wdata = q.ex_data;
          d.exec    = eeprom_seq_pkg::EX_IDLE;
        end
      end
      eeprom_seq_pkg::EX_VERIFY: begin
        mem_re    = 1'b1;
        d.rd_pend = 1'b1;
        if (q.rd_pend && (mem_rdata != eeprom_seq_pkg::ERASED_WORD)) begin
          d.blank_ok = 1'b0;
        end
        if (q.ex_addr == q.ex_end) begin
          d.exec = eeprom_seq_pkg::EX_VCHK;
        end else begin
          d.ex_addr = 10'(q.ex_addr + 10'd1);
        end
      end
      eeprom_seq_pkg::EX_VCHK: begin
        d.blank = q.blank_ok && (mem_rdata == eeprom_seq_pkg::ERASED_WORD);
        d.exec  = eeprom_seq_pkg::EX_IDLE;
      end
      default: begin
        d.exec = eeprom_seq_pkg::EX_IDLE;
      end
    endcase

    // the array port is shared, so cpu reads only get it while nothing runs
    if (array_rd_i) begin
      if (q.exec == eeprom_seq_pkg::EX_IDLE) begin
        mem_re        = 1'b1;
        mem_addr      = array_addr_i[10:1];
        d.rdata_valid = 1'b1;
      end else begin
        d.read_refused = 1'b1;
      end
    end

    d.ccif = (d.exec == eeprom_seq_pkg::EX_IDLE) && !d.buf_full;
    d.busy = (d.exec != eeprom_seq_pkg::EX_IDLE);
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q         <= '0;
      q.seq     <= eeprom_seq_pkg::SEQ_IDLE;
      q.exec    <= eeprom_seq_pkg::EX_IDLE;
      q.command_buffer_empty_flag   <= 1'b1;
      q.ccif    <= 1'b1;
      q.div_val <= eeprom_seq_pkg::CLKDIV_RESET;
      q.buf_cmd <= eeprom_seq_pkg::CMD_RESET;
    end else begin
      q <= d;
    end
  end

  assign array_rdata_o            = mem_rdata;
  assign array_rdata_valid_o      = q.rdata_valid;
  assign read_refused_o           = q.read_refused;
  assign clock_divider_register_o = q.div_val;
  assign busy_o                   = q.busy;
  assign status_register_o        = {q.command_buffer_empty_flag, q.ccif, 1'b0, q.access_error_flag, 1'b0, q.blank, 2'b00};

endmodule

`default_nettype wire

// ===== verif/eeprom_cpu_model.sv
// cpu side of the eeprom sequencer: one bus operation per task call
// assumes the bench calls op from one process only, never two at once
`timescale 1ns/100ps
`default_nettype none

module eeprom_cpu_model (
  // clock
  input  wire logic        clock_i,
  // bus towards the sequencer
  output var  logic        array_wr_o,
  output var  logic        array_byte_o,
  output var  logic        array_rd_o,
  output var  logic [10:0] array_addr_o,
  output var  logic [15:0] array_wdata_o,
  output var  logic        reg_wr_o,
  output var  logic [1:0]  reg_sel_o,
  output var  logic [7:0]  reg_wdata_o
);
  initial begin
    {array_wr_o, array_byte_o, array_rd_o, reg_wr_o} = 4'h0;
    array_addr_o = 11'h000;
    array_wdata_o = 16'h0000;
    reg_sel_o = 2'h0;
    reg_wdata_o = 8'h00;
  end

  // k: 0 idle, 1 word write, 2 byte write, 3 read, 4 register write (select in a)
  // unused lines show the inverse of their last value so stale data never matches
  task automatic op(input logic [2:0] k, input logic [10:0] a, input logic [15:0] d);
    @(posedge clock_i);
    array_wr_o    <= (k == 3'h1) || (k == 3'h2);
    array_byte_o  <= (k == 3'h2);
    array_rd_o    <= (k == 3'h3);
    reg_wr_o      <= (k == 3'h4);
    array_addr_o  <= (k inside {3'h1, 3'h2, 3'h3}) ? a : ~array_addr_o;
    array_wdata_o <= (k inside {3'h1, 3'h2}) ? d : ~array_wdata_o;
    reg_sel_o     <= (k == 3'h4) ? a[1:0] : ~reg_sel_o;
    reg_wdata_o   <= (k == 3'h4) ? d[7:0] : ~reg_wdata_o;
  endtask
endmodule

`default_nettype wire

// ===== verif/eeprom_seq_props.sv
// port assertions of the eeprom command sequencer
// assumes a single clock domain; bound into every sequencer instance
`timescale 1ns/100ps
`default_nettype none

module eeprom_seq_props (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // watched ports
  input  wire logic        array_wr_i,
  input  wire logic        array_byte_i,
  input  wire logic        array_rd_i,
  input  wire logic [10:0] array_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [1:0]  reg_sel_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        normal_mode_i,
  input  wire logic        array_rdata_valid_o,
  input  wire logic        read_refused_o,
  input  wire logic [7:0]  status_register_o,
  input  wire logic [6:0]  clock_divider_register_o,
  input  wire logic        busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic cmd_ok;
  logic is_cmd;
  assign cmd_ok = reg_wdata_i inside {8'h05, 8'h20, 8'h40, 8'h41, 8'h60};
  assign is_cmd = reg_wr_i && (reg_sel_i == eeprom_seq_pkg::REG_SEL_CMD);
  // a queued command waits for at most one running command; a full-array erase is the longest
  logic [17:0] buf_wait_q;
  logic [17:0] buf_wait_max;
  assign buf_wait_max = ((18'(clock_divider_register_o) + 18'h0_0001) << 10) + 18'h0_0040;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      buf_wait_q <= '0;
    end else if (status_register_o[7]) begin
      buf_wait_q <= '0;
    end else if (buf_wait_q != '1) begin
      buf_wait_q <= 18'(buf_wait_q + 18'h0_0001);
    end
  end
  // a legal word write, seen accepted one cycle later
  sequence s_word;
    array_wr_i && !array_byte_i && !array_addr_i[0] && status_register_o[7] ##1 !status_register_o[4];
  endsequence
  sequence s_cmd;
    s_word ##0 (is_cmd && cmd_ok) ##1 !status_register_o[4];
  endsequence

  AST_READ_OK: assert property (array_rd_i && !busy_o |=> array_rdata_valid_o && !read_refused_o)
    else $error("read while idle gave no data");
  AST_READ_REFUSED: assert property (array_rd_i && busy_o |=> read_refused_o && !array_rdata_valid_o)
    else $error("read while busy was not refused");
  AST_DONE_FLAG: assert property ($fell(busy_o) && status_register_o[7] |-> status_register_o[6])
    else $error("command end without complete flag");
  AST_BAD_WIDTH: assert property (array_wr_i && (array_byte_i || array_addr_i[0]) |=> status_register_o[4])
    else $error("byte or misaligned write not flagged");
  AST_NO_BUFFER: assert property (array_wr_i && !status_register_o[7] |=> status_register_o[4])
    else $error("write with full buffer not flagged");
  AST_SECOND_WORD: assert property (s_word ##0 array_wr_i |=> status_register_o[4])
    else $error("second word not flagged");
  AST_WORD_REG: assert property (s_word ##0 (reg_wr_i && !is_cmd) |=> status_register_o[4])
    else $error("register write after word not flagged");
  AST_BAD_CMD: assert property (s_word ##0 (is_cmd && !cmd_ok && normal_mode_i) |=> status_register_o[4])
    else $error("invalid command not flagged");
  AST_AFTER_CMD: assert property (s_cmd ##0 (array_wr_i || reg_wr_i && !(reg_sel_i == 2'h2 && reg_wdata_i[7]))
    |=> status_register_o[4])
    else $error("write after command not flagged");
  AST_LAUNCH: assert property (s_cmd ##0 (reg_wr_i && reg_sel_i == 2'h2 && reg_wdata_i[7])
    |=> !status_register_o[7] && !status_register_o[6])
    else $error("launch did not cycle the buffer flag");
  AST_BUF_FREE: assert property (buf_wait_q <= buf_wait_max)
    else $error("buffer empty flag stayed low too long");
endmodule

bind eeprom_command_sequencer eeprom_seq_props eeprom_seq_props_i (.clock_i, .reset_i, .array_wr_i, .array_byte_i,
  .array_rd_i, .array_addr_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .normal_mode_i, .array_rdata_valid_o,
  .read_refused_o, .status_register_o, .clock_divider_register_o, .busy_o);

`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench of the eeprom command sequencer
// assumes the cpu model drives all bus inputs; divider set to 1 keeps runs short
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic normal_mode = 1'b1;
  logic prot_dis = 1'b1;
  logic prot_open = 1'b1;
  logic aw, ab, ar, rw;
  logic [10:0] aa;
  logic [15:0] ad, rdata;
  logic [1:0] rs;
  logic [7:0] rd, stat;
  logic [6:0] div;
  logic valid, refused, busy;
  int fails = 0;
  int checks = 0;

  always #25 clock_i = ~clock_i;

  eeprom_cpu_model eeprom_cpu_model_i (.clock_i(clock_i), .array_wr_o(aw), .array_byte_o(ab), .array_rd_o(ar),
    .array_addr_o(aa), .array_wdata_o(ad), .reg_wr_o(rw), .reg_sel_o(rs), .reg_wdata_o(rd));
  eeprom_command_sequencer eeprom_command_sequencer_i (.clock_i(clock_i), .reset_i(reset_i), .array_wr_i(aw),
    .array_byte_i(ab), .array_rd_i(ar), .array_addr_i(aa), .array_wdata_i(ad), .reg_wr_i(rw), .reg_sel_i(rs),
    .reg_wdata_i(rd), .normal_mode_i(normal_mode), .protection_disable_bit_i(prot_dis),
    .protection_open_bit_i(prot_open), .array_rdata_o(rdata), .array_rdata_valid_o(valid),
    .read_refused_o(refused), .status_register_o(stat), .clock_divider_register_o(div), .busy_o(busy));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask
  task automatic op(input logic [2:0] k, input logic [10:0] a, input logic [15:0] d);
    eeprom_cpu_model_i.op(k, a, d);
  endtask
  task automatic nop();
    op(3'h0, 11'h000, 16'h0000);
    #1;
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    op(3'h1, a, d);
  endtask
  task automatic rg(input logic [1:0] s, input logic [7:0] d);
    op(3'h4, {9'h000, s}, {8'h00, d});
  endtask
  // word, command and launch on back-to-back cycles
  task automatic go(input logic [10:0] a, input logic [15:0] d, input logic [7:0] c);
    wr(a, d);
    rg(eeprom_seq_pkg::REG_SEL_CMD, c);
    rg(eeprom_seq_pkg::REG_SEL_STATUS, 8'h80);
  endtask
  // a verify queued behind a full-array erase needs about 3100 cycles at divider 1
  task automatic waitdone();
    int n;
    nop();
    n = 0;
    while ((busy !== 1'b0 || stat[7] !== 1'b1) && n < 5000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk1(n < 5000, 1'b1);
    chk1(stat[6], 1'b1);
  endtask
  task automatic run(input logic [10:0] a, input logic [15:0] d, input logic [7:0] c);
    go(a, d, c);
    waitdone();
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [15:0] e);
    op(3'h3, a, 16'h0000);
    nop();
    chk1(valid, 1'b1);
    chk(rdata, e);
  endtask

  task automatic t_start();
    chk({8'h00, stat}, 16'h00C0);
    wr(11'h000, 16'h0000);
    nop();
    chk1(stat[4], 1'b1);
    rg(eeprom_seq_pkg::REG_SEL_STATUS, 8'h10);
    rg(eeprom_seq_pkg::REG_SEL_CLKDIV, 8'h01);
    nop();
    chk({1'b0, stat, div}, 16'h6001);
    $display("test start done");
  endtask
  task automatic t_erase();
    go(11'h000, 16'h0000, eeprom_seq_pkg::CMD_MASS_ERASE);
    nop();
    op(3'h3, 11'h010, 16'h0000);
    nop();
    chk({14'h0000, refused, valid}, 16'h0002);
    run(11'h000, 16'h0000, eeprom_seq_pkg::CMD_ERASE_VERIFY);
    rdchk(11'h7FE, 16'hFFFF);
    run(11'h000, 16'h0000, eeprom_seq_pkg::CMD_ERASE_VERIFY);
    chk1(stat[2], 1'b1);
    $display("test erase done");
  endtask
  // only erased words are programmed throughout
  task automatic t_program();
    run(11'h010, 16'h1234, eeprom_seq_pkg::CMD_PROGRAM);
    rdchk(11'h010, 16'h1234);
    run(11'h000, 16'h0000, eeprom_seq_pkg::CMD_ERASE_VERIFY);
    chk1(stat[2], 1'b0);
    @(posedge clock_i) prot_dis <= 1'b0;
    run(11'h000, 16'h0000, eeprom_seq_pkg::CMD_MASS_ERASE);
    rdchk(11'h010, 16'h1234);
    @(posedge clock_i) prot_dis <= 1'b1;
    run(11'h014, 16'h4321, eeprom_seq_pkg::CMD_PROGRAM);
    run(11'h012, 16'h0000, eeprom_seq_pkg::CMD_SECTOR_ERASE);
    rdchk(11'h010, 16'hFFFF);
    rdchk(11'h014, 16'h4321);
    run(11'h012, 16'h2222, eeprom_seq_pkg::CMD_PROGRAM);
    go(11'h010, 16'h3333, eeprom_seq_pkg::CMD_SECTOR_MODIFY);
    nop();
    run(11'h012, 16'h4444, eeprom_seq_pkg::CMD_PROGRAM);
    rdchk(11'h010, 16'h3333);
    rdchk(11'h012, 16'h4444);
    $display("test program done");
  endtask
  task automatic t_errors();
    for (int i = 0; i < 9; i++) begin
      if (i == 0) op(3'h2, 11'h030, 16'h0000);
      else if (i == 1) wr(11'h031, 16'h0000);
      else if (i == 8) go(11'h020, 16'h0000, eeprom_seq_pkg::CMD_PROGRAM);
      else wr(11'h030, 16'h0000);
      if (i == 2 || i == 8) wr(11'h032, 16'h0000);
      if (i == 3) rg(2'h3, 8'h00);
      if (i >= 4 && i <= 7) rg(eeprom_seq_pkg::REG_SEL_CMD, (i == 5) ? 8'h77 : eeprom_seq_pkg::CMD_PROGRAM);
      if (i == 4) rg(eeprom_seq_pkg::REG_SEL_CMD, eeprom_seq_pkg::CMD_PROGRAM);
      if (i == 6) rg(eeprom_seq_pkg::REG_SEL_CLKDIV, 8'h01);
      if (i == 7) rg(eeprom_seq_pkg::REG_SEL_STATUS, 8'h00);
      nop();
      chk1(stat[4], 1'b1);
      rg(eeprom_seq_pkg::REG_SEL_STATUS, 8'h10);
      nop();
      chk1(stat[4], 1'b0);
    end
    @(posedge clock_i) normal_mode <= 1'b0;
    // special mode drops the bad code and keeps the latched word
    wr(11'h034, 16'h9999);
    rg(eeprom_seq_pkg::REG_SEL_CMD, 8'h77);
    rg(eeprom_seq_pkg::REG_SEL_CMD, eeprom_seq_pkg::CMD_PROGRAM);
    rg(eeprom_seq_pkg::REG_SEL_STATUS, 8'h80);
    waitdone();
    chk1(stat[4], 1'b0);
    rdchk(11'h034, 16'h9999);
    wr(11'h036, 16'h0000);
    wr(11'h038, 16'h0000);
    nop();
    chk1(stat[4], 1'b1);
    $display("test errors done");
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    nop();
    t_start();
    t_erase();
    t_program();
    t_errors();
    end_sim();
  end
endmodule

`default_nettype wire
